//--- logic/vsq_core.sv
// setpoint, margin, trim and on/off sequencing core of the buck converter
//
// Contract
// - separate input turn-on and turn-off thresholds
// - on/off configuration selects start condition sources
// - wait turn-on delay before regulating
// - wait turn-off delay before stopping
// - operation top bit switches conversion
// - reference code stays within dac span
// - averaged output voltage kept as telemetry
// - only ratios one, half, quarter accepted
// - command valid range depends on ratio
// - limit violation substitutes limit, sets status
// - signed trim -64..+63 added to reference
// - margin high/low offsets -64..31 held
// - operation selects none, high or low margin
// - loop ratio maps command onto reference
`timescale 1ns/1ps
module vsq_core #(
    parameter int MS_CYCLES = vsq_pkg::MS_CYCLES,
    parameter int AVG_LOG2  = 2
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // command port
    input  wire vsq_pkg::vsq_cmd_s      cmd,
    output logic [15:0]                 rdData,
    output logic                        rdValid,
    // pins and sensed levels
    input  wire logic                   enableControlPin,
    input  wire logic [15:0]            vinLevel,
    input  wire logic                   adcValid,
    input  wire logic [11:0]            senseAmpOutput,
    // converter control
    output logic                        regulate,
    output logic [9:0]                  errorAmpReference
);
    localparam int PW = $clog2(MS_CYCLES + 1);

    // ==========================================
    // elaboration checks: refuse a prescaler or average depth the logic cannot serve
    if (MS_CYCLES < 1 || AVG_LOG2 < 0 || AVG_LOG2 > 4) begin : gBadParams
        $error("vsq_core: unsupported parameters");
    end

    // ==========================================
    // registers
    logic [7:0]        operation_q;
    logic [7:0]        onOffCfg_q;
    logic [15:0]       voutCmd_q;
    logic [15:0]       voutMax_q;
    logic [15:0]       voutMin_q;
    logic [15:0]       scale_q;
    logic [15:0]       vinOn_q;
    logic [15:0]       vinOff_q;
    logic [6:0]        tonDly_q;
    logic [6:0]        toffDly_q;
    logic signed [6:0] trim_q;
    logic signed [6:0] mrgHigh_q;
    logic signed [6:0] mrgLow_q;
    logic [7:0]        status_q;
    logic [15:0]       readVout_q;
    logic              wrHit;
    logic [15:0]       cmdClamped;
    logic              overMax;
    logic              underMin;

    assign wrHit = cmd.wr;

    // clamp a delay write to the 100 ms ceiling
    function automatic logic [6:0] clampDelay(input logic [15:0] v);
        clampDelay = (v > 16'(vsq_pkg::DELAY_MAX_MS)) ? vsq_pkg::DELAY_MAX_MS : v[6:0];
    endfunction

    // clamp a margin write; field is 7-bit signed, top limited to +31
    function automatic logic signed [6:0] clampMargin(input logic [15:0] v);
        clampMargin = ($signed(v[6:0]) > vsq_pkg::MRG_MAX) ? vsq_pkg::MRG_MAX : $signed(v[6:0]);
    endfunction

    // clamp an input threshold into 4 V .. 7.75 V
    function automatic logic [15:0] clampVin(input logic [15:0] v);
        if (v < vsq_pkg::VIN_FLOOR) begin
            clampVin = vsq_pkg::VIN_FLOOR;
        end else if (v > vsq_pkg::VIN_CEIL) begin
            clampVin = vsq_pkg::VIN_CEIL;
        end else begin
            clampVin = v;
        end
    endfunction

    // range of a valid command for the present loop ratio
    function automatic logic [31:0] cmdRange(input logic [15:0] s);
        unique case (s)
            vsq_pkg::SCALE_HALF:    cmdRange = {vsq_pkg::CMD_MIN_HALF, vsq_pkg::CMD_MAX_HALF};
            vsq_pkg::SCALE_QUARTER: cmdRange = {vsq_pkg::CMD_MIN_QTR, vsq_pkg::CMD_MAX_QTR};
            default:                cmdRange = {vsq_pkg::DAC_MIN, vsq_pkg::DAC_MAX};
        endcase
    endfunction

    // substitute the violated limit, then fold into the ratio range
    always_comb begin
        logic [31:0] rng;
        rng        = cmdRange(scale_q);
        overMax    = cmd.data > voutMax_q;
        underMin   = cmd.data < voutMin_q;
        cmdClamped = overMax ? voutMax_q : (underMin ? voutMin_q : cmd.data);
        if (cmdClamped > rng[15:0]) begin
            cmdClamped = rng[15:0];
        end else if (cmdClamped < rng[31:16]) begin
            cmdClamped = rng[31:16];
        end
    end

    // writable configuration; command, delay, threshold and margin writes are saturated, illegal ratio writes are dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            operation_q <= vsq_pkg::RST_OPERATION;
            onOffCfg_q  <= vsq_pkg::RST_ONOFF_CFG;
            voutCmd_q   <= vsq_pkg::RST_VOUT_CMD;
            voutMax_q   <= vsq_pkg::CMD_MAX_QTR;
            voutMin_q   <= vsq_pkg::DAC_MIN;
            scale_q     <= vsq_pkg::SCALE_ONE;
            vinOn_q     <= vsq_pkg::RST_INPUT_TURN_ON_THRESHOLD;
            vinOff_q    <= vsq_pkg::RST_INPUT_TURN_OFF_THRESHOLD;
            tonDly_q    <= vsq_pkg::RST_DELAY[6:0];
            toffDly_q   <= vsq_pkg::RST_DELAY[6:0];
            trim_q      <= '0;
            mrgHigh_q   <= '0;
            mrgLow_q    <= '0;
        end else if (wrHit) begin
            unique case (cmd.code)
                vsq_pkg::CMD_OPERATION: operation_q <= cmd.data[7:0];
                vsq_pkg::CMD_ONOFF_CFG: onOffCfg_q  <= cmd.data[7:0];
                vsq_pkg::CMD_VOUT_CMD:  voutCmd_q   <= cmdClamped;
                vsq_pkg::CMD_VOUT_MAX:  voutMax_q   <= cmd.data;
                vsq_pkg::CMD_VOUT_MIN:  voutMin_q   <= cmd.data;
                vsq_pkg::CMD_SCALE_LOOP: begin
                    if (cmd.data == vsq_pkg::SCALE_ONE || cmd.data == vsq_pkg::SCALE_HALF
                        || cmd.data == vsq_pkg::SCALE_QUARTER) begin
                        scale_q <= cmd.data;
                    end
                end
                vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD:    vinOn_q     <= clampVin(cmd.data);
                vsq_pkg::CMD_INPUT_TURN_OFF_THRESHOLD:   vinOff_q    <= clampVin(cmd.data);
                vsq_pkg::CMD_TON_DLY:   tonDly_q    <= clampDelay(cmd.data);
                vsq_pkg::CMD_TOFF_DLY:  toffDly_q   <= clampDelay(cmd.data);
                vsq_pkg::CMD_TRIM:      trim_q      <= $signed(cmd.data[6:0]);
                vsq_pkg::CMD_MRG_HIGH:  mrgHigh_q   <= clampMargin(cmd.data);
                vsq_pkg::CMD_MRG_LOW:   mrgLow_q    <= clampMargin(cmd.data);
                default: ;
            endcase
        end
    end

    // status: a limit hit sets its bit and wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            logic [7:0] setBits;
            logic [7:0] clrBits;
            setBits = '0;
            clrBits = '0;
            if (wrHit && cmd.code == vsq_pkg::CMD_VOUT_CMD) begin
                setBits[vsq_pkg::STS_MAX_BIT] = overMax;
                setBits[vsq_pkg::STS_MIN_BIT] = underMin;
            end
            if (wrHit && cmd.code == vsq_pkg::CMD_STATUS) begin
                clrBits = cmd.data[7:0];
            end
            status_q <= (status_q & ~clrBits) | setBits;
        end
    end

    // ==========================================
    // input undervoltage lockout with hysteresis
    logic vinOk_q;
    // on above one level, off below the other
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vinOk_q <= 1'b0;
        end else if (!vinOk_q && vinLevel >= vinOn_q) begin
            vinOk_q <= 1'b1;
        end else if (vinOk_q && vinLevel < vinOff_q) begin
            vinOk_q <= 1'b0;
        end
    end

    // ==========================================
    // start condition and sequencer
    logic            pinActive;
    logic            startCond;
    vsq_pkg::vsq_seq_e seq_q;
    logic [PW-1:0]   presc_q;
    logic [6:0]      msCnt_q;
    logic            msTick;

    assign pinActive = enableControlPin == onOffCfg_q[vsq_pkg::CFG_PIN_POL];
    // each source gates only when selected
    // top operation bit is the on/off command
    assign startCond = vinOk_q
        && (!onOffCfg_q[vsq_pkg::CFG_USE_OP] || operation_q[vsq_pkg::OP_ON_BIT])
        && (!onOffCfg_q[vsq_pkg::CFG_USE_PIN] || pinActive);
    assign msTick = presc_q == PW'(MS_CYCLES - 1);

    // millisecond prescaler restarts on every state change so delays are whole
    always_ff @(posedge mclk) begin
        if (!rst_n || seq_q == vsq_pkg::SEQ_OFF || seq_q == vsq_pkg::SEQ_REG || msTick) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + PW'(1);
        end
    end

    // elapsed milliseconds in a wait state
    always_ff @(posedge mclk) begin
        if (!rst_n || seq_q == vsq_pkg::SEQ_OFF || seq_q == vsq_pkg::SEQ_REG) begin
            msCnt_q <= '0;
        end else if (msTick) begin
            msCnt_q <= msCnt_q + 7'h01;
        end
    end

    // sequencer; a wait aborted by the condition returns without a glitch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seq_q <= vsq_pkg::SEQ_OFF;
        end else begin
            unique case (seq_q)
                vsq_pkg::SEQ_OFF:    if (startCond) seq_q <= vsq_pkg::SEQ_ONWAIT;
                vsq_pkg::SEQ_ONWAIT: begin
                    if (!startCond) begin
                        seq_q <= vsq_pkg::SEQ_OFF;
                    end else if (msCnt_q >= tonDly_q) begin
                        seq_q <= vsq_pkg::SEQ_REG;
                    end
                end
                vsq_pkg::SEQ_REG:    if (!startCond) seq_q <= vsq_pkg::SEQ_OFFWT;
                vsq_pkg::SEQ_OFFWT: begin
                    if (startCond) begin
                        seq_q <= vsq_pkg::SEQ_REG;
                    end else if (msCnt_q >= toffDly_q) begin
                        seq_q <= vsq_pkg::SEQ_OFF;
                    end
                end
                default: seq_q <= vsq_pkg::SEQ_OFF;
            endcase
        end
    end

    // regulation output follows the sequencer one cycle later
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regulate <= 1'b0;
        end else begin
            regulate <= seq_q == vsq_pkg::SEQ_REG || seq_q == vsq_pkg::SEQ_OFFWT;
        end
    end

    // ==========================================
    // reference code
    logic signed [17:0] refSum;
    logic [15:0]        scaled;
    logic signed [6:0]  mrgSel;
    logic [9:0]         refCode;

    // ratio as a right shift of the command
    assign scaled = (scale_q == vsq_pkg::SCALE_QUARTER) ? voutCmd_q >> 2 :
                    (scale_q == vsq_pkg::SCALE_HALF) ? voutCmd_q >> 1 : voutCmd_q;
    // high wins if both margin bits are set
    assign mrgSel = operation_q[vsq_pkg::OP_MRG_HI] ? mrgHigh_q :
                    operation_q[vsq_pkg::OP_MRG_LO] ? mrgLow_q : 7'sh00;
    // sum of scaled command, trim and margin
    assign refSum = $signed({2'b00, scaled}) + 18'(trim_q) + 18'(mrgSel);
    assign refCode = (refSum < $signed({2'b00, vsq_pkg::DAC_MIN})) ? vsq_pkg::DAC_MIN[9:0] :
                     (refSum > $signed({2'b00, vsq_pkg::DAC_MAX})) ? vsq_pkg::DAC_MAX[9:0] :
                     refSum[9:0];

    // registered dac drive
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            errorAmpReference <= vsq_pkg::DAC_MIN[9:0];
        end else begin
            errorAmpReference <= refCode;
        end
    end

    // ==========================================
    // output voltage telemetry
    logic [11+AVG_LOG2:0] acc_q;
    logic [AVG_LOG2:0]    nSmp_q;
    logic                 avgDone;

    assign avgDone = adcValid && nSmp_q == (AVG_LOG2+1)'((1 << AVG_LOG2) - 1);

    // block average of 2^AVG_LOG2 samples, trades latency for noise
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acc_q      <= '0;
            nSmp_q     <= '0;
            readVout_q <= '0;
        end else if (adcValid) begin
            acc_q  <= avgDone ? '0 : acc_q + (12+AVG_LOG2)'(senseAmpOutput);
            nSmp_q <= avgDone ? '0 : nSmp_q + (AVG_LOG2+1)'(1);
            if (avgDone) begin
                readVout_q <= 16'((acc_q + (12+AVG_LOG2)'(senseAmpOutput)) >> AVG_LOG2);
            end
        end
    end

    // ==========================================
    // read port: answer one cycle after the strobe; unknown codes read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData  <= '0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= cmd.rd;
            if (cmd.rd) begin
                unique case (cmd.code)
                    vsq_pkg::CMD_OPERATION:  rdData <= {8'h00, operation_q};
                    vsq_pkg::CMD_ONOFF_CFG:  rdData <= {8'h00, onOffCfg_q};
                    vsq_pkg::CMD_VOUT_CMD:   rdData <= voutCmd_q;
                    vsq_pkg::CMD_VOUT_MAX:   rdData <= voutMax_q;
                    vsq_pkg::CMD_VOUT_MIN:   rdData <= voutMin_q;
                    vsq_pkg::CMD_SCALE_LOOP: rdData <= scale_q;
                    vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD:     rdData <= vinOn_q;
                    vsq_pkg::CMD_INPUT_TURN_OFF_THRESHOLD:    rdData <= vinOff_q;
                    vsq_pkg::CMD_TON_DLY:    rdData <= {9'h000, tonDly_q};
                    vsq_pkg::CMD_TOFF_DLY:   rdData <= {9'h000, toffDly_q};
                    vsq_pkg::CMD_STATUS:     rdData <= {8'h00, status_q};
                    vsq_pkg::CMD_READ_VOUT:  rdData <= readVout_q;
                    vsq_pkg::CMD_TRIM:       rdData <= 16'(trim_q);
                    vsq_pkg::CMD_MRG_HIGH:   rdData <= 16'(mrgHigh_q);
                    vsq_pkg::CMD_MRG_LOW:    rdData <= 16'(mrgLow_q);
                    default:                 rdData <= '0;
                endcase
            end
        end
    end

    // ==========================================
    // assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_vin_lockout: assert property (vinOk_q && vinLevel < vinOff_q |=> !vinOk_q)
        else $error("lockout did not engage");
    chk_start_gate: assert property ($rose(regulate) |-> $past(startCond, 2))
        else $error("regulation began without start condition");
    chk_on_delay: assert property ($rose(regulate) |-> $past(msCnt_q, 2) >= $past(tonDly_q, 2))
        else $error("regulation began before turn-on delay");
    chk_off_delay: assert property ($fell(regulate) |-> $past(msCnt_q, 2) >= $past(toffDly_q, 2))
        else $error("regulation stopped before turn-off delay");
    chk_op_off: assert property (onOffCfg_q[vsq_pkg::CFG_USE_OP] && !operation_q[vsq_pkg::OP_ON_BIT]
        && seq_q == vsq_pkg::SEQ_OFF |=> seq_q == vsq_pkg::SEQ_OFF)
        else $error("started while operation is off");
    chk_dac_span: assert property (errorAmpReference >= vsq_pkg::DAC_MIN[9:0]
        && errorAmpReference <= vsq_pkg::DAC_MAX[9:0])
        else $error("reference outside dac span");
    chk_tele_load: assert property (avgDone |=> readVout_q == 16'(($past(acc_q)
        + (12+AVG_LOG2)'($past(senseAmpOutput))) >> AVG_LOG2))
        else $error("telemetry not the block average");
    chk_ratio_legal: assert property (scale_q == vsq_pkg::SCALE_ONE || scale_q == vsq_pkg::SCALE_HALF
        || scale_q == vsq_pkg::SCALE_QUARTER)
        else $error("illegal loop ratio stored");
    chk_max_subst: assert property (wrHit && cmd.code == vsq_pkg::CMD_VOUT_CMD && overMax |=>
        status_q[vsq_pkg::STS_MAX_BIT] && voutCmd_q <= $past(voutMax_q))
        else $error("upper limit not substituted");
    chk_ratio_range: assert property (scale_q == vsq_pkg::SCALE_ONE && $changed(voutCmd_q) |->
        voutCmd_q >= vsq_pkg::DAC_MIN && voutCmd_q <= vsq_pkg::DAC_MAX)
        else $error("command outside ratio range");
    chk_ref_sum: assert property (##1 $past(refSum) >= $signed({2'b00, vsq_pkg::DAC_MIN})
        && $past(refSum) <= $signed({2'b00, vsq_pkg::DAC_MAX})
        |-> errorAmpReference == $past(refSum[9:0]))
        else $error("reference not scaled command plus offsets");
    chk_margin_sel: assert property (operation_q[vsq_pkg::OP_MRG_HI] |-> mrgSel == mrgHigh_q)
        else $error("margin high not selected");

    cov_turn_on:  cover property (seq_q == vsq_pkg::SEQ_ONWAIT ##[1:8] seq_q == vsq_pkg::SEQ_REG);
    cov_turn_off: cover property ($fell(regulate));
    cov_clamp:    cover property (wrHit && cmd.code == vsq_pkg::CMD_VOUT_CMD && underMin);
    cov_margin:   cover property (operation_q[vsq_pkg::OP_MRG_LO] && regulate);
endmodule

//--- logic/vsq_pkg.sv
// package: command codes, field layouts, limits and timing for the setpoint and sequencing core
package vsq_pkg;
    // ==========================================
    // command codes
    localparam logic [7:0] CMD_OPERATION  = 8'h01;
    localparam logic [7:0] CMD_ONOFF_CFG  = 8'h02;
    localparam logic [7:0] CMD_VOUT_CMD   = 8'h21;
    localparam logic [7:0] CMD_VOUT_MAX   = 8'h24;
    localparam logic [7:0] CMD_VOUT_MIN   = 8'h28;
    localparam logic [7:0] CMD_SCALE_LOOP = 8'h29;
    localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD     = 8'h35;
    localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD    = 8'h36;
    localparam logic [7:0] CMD_TON_DLY    = 8'h60;
    localparam logic [7:0] CMD_TOFF_DLY   = 8'h64;
    localparam logic [7:0] CMD_STATUS     = 8'h7a;
    localparam logic [7:0] CMD_READ_VOUT  = 8'h8b;
    localparam logic [7:0] CMD_TRIM       = 8'hd4;
    localparam logic [7:0] CMD_MRG_HIGH   = 8'hd5;
    localparam logic [7:0] CMD_MRG_LOW    = 8'hd6;
    // ==========================================
    // field positions
    localparam int OP_ON_BIT     = 7;
    localparam int OP_MRG_HI     = 5;
    localparam int OP_MRG_LO     = 4;
    localparam int CFG_USE_OP    = 3;
    localparam int CFG_USE_PIN   = 2;
    localparam int CFG_PIN_POL   = 1;
    localparam int STS_MAX_BIT   = 3;
    localparam int STS_MIN_BIT   = 2;
    // loop ratio encodings (quarter units)
    localparam logic [15:0] SCALE_ONE     = 16'h0004;
    localparam logic [15:0] SCALE_HALF    = 16'h0002;
    localparam logic [15:0] SCALE_QUARTER = 16'h0001;
    // ==========================================
    // limits and reset values (dac steps of 1.953 mV, input in 0.25 V)
    localparam logic [15:0] DAC_MIN       = 16'h00b3; // 179
    localparam logic [15:0] DAC_MAX       = 16'h034d; // 845
    localparam logic [15:0] CMD_MIN_HALF  = 16'h0166; // 358
    localparam logic [15:0] CMD_MAX_HALF  = 16'h069a; // 1690
    localparam logic [15:0] CMD_MIN_QTR   = 16'h02cc; // 716
    localparam logic [15:0] CMD_MAX_QTR   = 16'h0b00; // 2816
    localparam logic [15:0] VIN_FLOOR     = 16'h0010; // 4 V
    localparam logic [15:0] VIN_CEIL      = 16'h001f; // 7.75 V
    localparam logic [15:0] RST_VOUT_CMD  = 16'h0133;
    localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD    = 16'h0012;
    localparam logic [15:0] RST_INPUT_TURN_OFF_THRESHOLD   = 16'h0010;
    localparam logic [7:0]  RST_OPERATION = 8'h00;
    localparam logic [7:0]  RST_ONOFF_CFG = 8'h00;
    localparam logic [6:0]  DELAY_MAX_MS  = 7'h64;    // 100 ms
    localparam logic signed [6:0] MRG_MAX = 7'sh1f;   // +31
    localparam logic [15:0] RST_DELAY     = 16'h0000;
    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_TIME_NS    = 1000000;
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } vsq_cmd_s;

    typedef enum logic [3:0] {
        SEQ_OFF    = 4'b0001,
        SEQ_ONWAIT = 4'b0010,
        SEQ_REG    = 4'b0100,
        SEQ_OFFWT  = 4'b1000
    } vsq_seq_e;
endpackage

//--- verif/vout_setpoint_and_sequencing_tb_top.sv
// self-checking bench of the setpoint and sequencing core
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module vout_setpoint_and_sequencing_tb_top;
    logic              mclk;
    logic              rst_n;
    vsq_pkg::vsq_cmd_s cmd;
    logic [15:0]       rdData, vin, d;
    logic              rdValid, pin, adcValid, regulate;
    logic [11:0]       sense;
    logic [9:0]        eaRef;
    int                error_cnt = 0;
    int                total_checks = 0;

    // ==========================================
    // short millisecond so delays stay a few dozen cycles
    vsq_core #(.MS_CYCLES(10)) DUT (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .rdData(rdData),
        .rdValid(rdValid), .enableControlPin(pin), .vinLevel(vin), .adcValid(adcValid),
        .senseAmpOutput(sense), .regulate(regulate), .errorAmpReference(eaRef));
    vsq_host_model HOST (.mclk(mclk), .cmd(cmd), .rdData(rdData), .rdValid(rdValid),
        .pin(pin), .vin(vin), .adcValid(adcValid), .sense(sense));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] c, input logic [15:0] e, input string n);
        HOST.rd(c, d);
        `CHK("rdValid", 1'b1, rdValid)
        `CHK(n, e, d)
    endtask
    // reference lands one cycle after the write edge
    task automatic refchk(input logic [9:0] e);
        @(negedge mclk);
        `CHK("eaRef", e, eaRef)
    endtask
    task automatic waitreg(input logic v, input int lim);
        for (int n = 0; n < lim && regulate !== v; n++) @(negedge mclk);
        `CHK("regulate", v, regulate)
    endtask
    // regulate must keep its level on every one of n cycles
    task automatic holdreg(input logic v, input int n);
        repeat (n) begin
            @(negedge mclk);
            `CHK("regulateHeld", v, regulate)
        end
    endtask

    // ==========================================
    task automatic t_reset;
        rdchk(vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD, 16'h0012, "vinOn");
        rdchk(vsq_pkg::CMD_SCALE_LOOP, 16'h0004, "ratio");
        `CHK("eaRef", 10'h133, eaRef)
        HOST.wr(vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD, 16'h0028);
        rdchk(vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD, 16'h001f, "vinOnCeil");
        HOST.wr(vsq_pkg::CMD_INPUT_TURN_OFF_THRESHOLD, 16'h0002);
        rdchk(vsq_pkg::CMD_INPUT_TURN_OFF_THRESHOLD, 16'h0010, "vinOffFloor");
        HOST.wr(vsq_pkg::CMD_INPUT_TURN_ON_THRESHOLD, 16'h0014);
    endtask
    task automatic t_scale;
        HOST.wr(vsq_pkg::CMD_SCALE_LOOP, 16'h0002);
        HOST.wr(vsq_pkg::CMD_SCALE_LOOP, 16'h0003);
        rdchk(vsq_pkg::CMD_SCALE_LOOP, 16'h0002, "ratioBad");
        HOST.wr(vsq_pkg::CMD_VOUT_CMD, 16'h03e8);
        refchk(10'h1f4);
        HOST.wr(vsq_pkg::CMD_SCALE_LOOP, 16'h0001);
        HOST.wr(vsq_pkg::CMD_VOUT_CMD, 16'h0200);
        rdchk(vsq_pkg::CMD_VOUT_CMD, 16'h02cc, "cmdQtr");
        HOST.wr(vsq_pkg::CMD_SCALE_LOOP, 16'h0004);
    endtask
    task automatic t_limit;
        HOST.wr(vsq_pkg::CMD_VOUT_MAX, 16'h0190);
        HOST.wr(vsq_pkg::CMD_VOUT_CMD, 16'h01f4);
        rdchk(vsq_pkg::CMD_VOUT_CMD, 16'h0190, "cmdMax");
        rdchk(vsq_pkg::CMD_STATUS, 16'h0008, "stsMax");
        HOST.wr(vsq_pkg::CMD_STATUS, 16'h000c);
        HOST.wr(vsq_pkg::CMD_VOUT_MIN, 16'h00c8);
        HOST.wr(vsq_pkg::CMD_VOUT_CMD, 16'h0064);
        rdchk(vsq_pkg::CMD_VOUT_CMD, 16'h00c8, "cmdMin");
        rdchk(vsq_pkg::CMD_STATUS, 16'h0004, "stsMin");
    endtask
    task automatic t_offset;
        HOST.wr(vsq_pkg::CMD_TRIM, 16'h0040);
        refchk(10'h0b3);
        HOST.wr(vsq_pkg::CMD_TRIM, 16'h003f);
        refchk(10'h107);
        HOST.wr(vsq_pkg::CMD_MRG_HIGH, 16'h0028);
        rdchk(vsq_pkg::CMD_MRG_HIGH, 16'h001f, "mrgHigh");
        HOST.wr(vsq_pkg::CMD_MRG_LOW, 16'h0070);
        HOST.wr(vsq_pkg::CMD_OPERATION, 16'h0010);
        refchk(10'h0f7);
        HOST.wr(vsq_pkg::CMD_OPERATION, 16'h0030);
        refchk(10'h126);
        HOST.wr(vsq_pkg::CMD_OPERATION, 16'h0000);
    endtask
    // on delay 2 ms, off delay 1 ms, gated by the operation top bit then the pin
    task automatic t_seq;
        HOST.wr(vsq_pkg::CMD_ONOFF_CFG, 16'h0008);
        HOST.wr(vsq_pkg::CMD_TON_DLY, 16'h0002);
        HOST.wr(vsq_pkg::CMD_TOFF_DLY, 16'h0001);
        HOST.vin = 16'h0020;
        HOST.wr(vsq_pkg::CMD_OPERATION, 16'h0080);
        holdreg(1'b0, 20);
        waitreg(1'b1, 5);
        HOST.wr(vsq_pkg::CMD_OPERATION, 16'h0000);
        holdreg(1'b1, 10);
        waitreg(1'b0, 5);
        HOST.wr(vsq_pkg::CMD_ONOFF_CFG, 16'h0006);
        holdreg(1'b0, 8);
        HOST.pin = 1'b1;
        holdreg(1'b0, 20);
        waitreg(1'b1, 5);
        HOST.vin = 16'h000f;
        waitreg(1'b0, 30);
    endtask
    task automatic t_telem;
        HOST.sample(12'h064);
        HOST.sample(12'h068);
        HOST.sample(12'h06c);
        HOST.sample(12'h070);
        HOST.wr(vsq_pkg::CMD_READ_VOUT, 16'h0555);
        rdchk(vsq_pkg::CMD_READ_VOUT, 16'h006a, "readVout");
    endtask

    // ==========================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        t_reset;
        t_scale;
        t_limit;
        t_offset;
        t_seq;
        t_telem;
        end_of_test;
    end

    // watchdog: the run needs well under 2000 cycles
    initial begin
        #50000;
        error_cnt++;
        end_of_test;
    end
endmodule

//--- verif/vsq_host_model.sv
// host model: command writes and reads, enable pin, input level and sense samples
`timescale 1ns/1ps
module vsq_host_model (
    // clock
    input  wire logic         mclk,
    // command port
    output vsq_pkg::vsq_cmd_s cmd,
    input  wire logic [15:0]  rdData,
    input  wire logic         rdValid,
    // pins and sensed levels
    output logic              pin,
    output logic [15:0]       vin,
    output logic              adcValid,
    output logic [11:0]       sense
);
    // ==========================================
    // idle values; released data shows its inverse so stale data never matches
    initial begin
        cmd = '0;
        pin = 1'b0;
        vin = 16'h0000;
        adcValid = 1'b0;
        sense = 12'h000;
    end

    // one write, strobe held across exactly one rising edge
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge mclk);
        cmd = {1'b1, 1'b0, c, d};
        @(negedge mclk);
        cmd = {1'b0, 1'b0, c, ~d};
    endtask

    // one read; the answer may come late, so wait a bounded time
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        int n;
        @(negedge mclk);
        cmd = {1'b0, 1'b1, c, ~cmd.data};
        @(negedge mclk);
        cmd.rd = 1'b0;
        for (n = 0; n < 3 && rdValid !== 1'b1; n++) @(negedge mclk);
        d = rdData;
    endtask

    // one sense sample pulse
    task automatic sample(input logic [11:0] v);
        @(negedge mclk);
        adcValid = 1'b1;
        sense = v;
        @(negedge mclk);
        adcValid = 1'b0;
        sense = ~v;
    endtask
endmodule
